//--- neg_seq_overcurrent_defs.svh
`ifndef NEG_SEQ_OVERCURRENT_DEFS_SVH
`define NEG_SEQ_OVERCURRENT_DEFS_SVH

// register byte offsets
`define REG_CURVE        8'h00
`define REG_PICKUP       8'h04
`define REG_DEF_DELAY    8'h08
`define REG_MIN_DELAY    8'h0C
`define REG_RST_DELAY    8'h10
`define REG_MULT         8'h14
`define REG_STATUS       8'h18
`define REG_IRQ_STATUS   8'h1C
`define REG_IRQ_MASK     8'h20
`define REG_ELAPSED      8'h24

// field positions
`define ST_START_BIT     0
`define ST_TRIP_BIT      1
`define ST_PHASE_LSB     2
`define ST_BIN_LSB       4
`define IRQ_START_BIT    0
`define IRQ_TRIP_BIT     1

// reset values and setting ranges
`define PICKUP_RESET     8'h32
`define PICKUP_MIN       8'h05
`define PICKUP_MAX       8'hC8
`define DELAY_RESET      16'h0064
`define DELAY_MAX        16'hEA60
`define MULT_RESET       16'h0064
`define MULT_MIN         16'h0064
`define MULT_MAX         16'hEA60

// timing
`define CLK_PERIOD_NS    100
`define MS_TIME_NS       1000000
`define MS_CYCLES        (`MS_TIME_NS / `CLK_PERIOD_NS)

// measurement scaling
`define NOM_UNITS        1000
`define SQRT3_Q10        1774
`define DROP_NUM         361
`define DROP_DEN         400
`define FLATTEN_BIN      4'hA

`endif

//--- neg_seq_overcurrent_element.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "neg_seq_overcurrent_defs.svh"

module neg_seq_overcurrent_element #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int NOM_UNITS = `NOM_UNITS
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [15:0] ia_re,
  input  wire logic signed [15:0] ia_im,
  input  wire logic signed [15:0] ib_re,
  input  wire logic signed [15:0] ib_im,
  input  wire logic signed [15:0] ic_re,
  input  wire logic signed [15:0] ic_im,
  input  wire logic               phasor_valid,
  input  wire logic               element_disable,
  output logic                    start,
  output logic                    trip,
  output logic                    irq
);
  import neg_seq_overcurrent_pkg::*;

  typedef struct packed {
    curve_t             curve;
    logic [7:0]         pickup;
    logic [15:0]        def_delay;
    logic [15:0]        min_delay;
    logic [15:0]        rst_delay;
    logic [15:0]        mult;
    logic [1:0]         irq_status;
    logic [1:0]         irq_mask;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic signed [17:0] x;
    logic signed [17:0] y;
    logic               xy_valid;
    logic [35:0]        mag2;
    logic               mag_valid;
    logic [3:0]         bin;
    logic               started;
    logic               trip;
    logic               irq;
    phase_t             phase;
    logic [31:0]        tick_cnt;
    logic [31:0]        elapsed;
    logic [15:0]        rst_cnt;
  } state_t;

  localparam logic [31:0] NOM6 = 32'(6 * NOM_UNITS);

  // curve factor 1/(m^alpha - 1) in q10 (q14 for alpha two), bins 0..10 at ratio
  // 1.05,1.25,1.5,2,2.5,3,4,5,7,10,20; lower edges keep times conservative
  localparam logic [10:0][20:0] D_A002 = {
    21'h040C8, 21'h054E0, 21'h064CB, 21'h07A48, 21'h08E48, 21'h0B40E,
    21'h0D847, 21'h11E8B, 21'h1EB48, 21'h37E48, 21'h100133};
  localparam logic [10:0][20:0] D_A1 = {
    21'h00036, 21'h00072, 21'h000AB, 21'h00100, 21'h00155, 21'h00200,
    21'h002AB, 21'h00400, 21'h00800, 21'h01000, 21'h05000};
  // alpha two table is q14: q10 loses about a fifth of the flatten value at 20x
  localparam logic [10:0][20:0] D_A2 = {
    21'h00029, 21'h000A6, 21'h00155, 21'h002AB, 21'h00444, 21'h00800,
    21'h00C31, 21'h01555, 21'h03333, 21'h071C7, 21'h27064};
  // 16 * ratio^2 at each bin boundary
  localparam logic [9:0][15:0] BIN_SQ = {
    16'h1900, 16'h0640, 16'h0310, 16'h0190, 16'h0100,
    16'h0090, 16'h0064, 16'h0040, 16'h0024, 16'h0019};

  // returns {alpha class, k * 1e4, c * 1e4}
  function automatic logic [35:0] curve_par(input curve_t cv);
    logic [35:0] r;
    r = 36'h0;
    unique case (cv)
      IEC_INV:            r = {2'h0, 21'h00578, 13'h0000};
      IEC_VERY_INV:       r = {2'h1, 21'h20F58, 13'h0000};
      IEC_EXT_INV:        r = {2'h2, 21'h0C3500, 13'h0000};
      IEC_LONG_INV:       r = {2'h1, 21'h124F80, 13'h0000};
      ANSI_INV:           r = {2'h0, 21'h00056, 13'h00B9};
      ANSI_MOD_INV:       r = {2'h0, 21'h00203, 13'h0474};
      ANSI_VERY_INV:      r = {2'h2, 21'h2FE04, 13'h132E};
      ANSI_EXT_INV:       r = {2'h2, 21'h44D90, 13'h04C1};
      ANSI_LONG_INV:      r = {2'h0, 21'h0035C, 13'h073A};
      ANSI_LONG_VERY_INV: r = {2'h2, 21'h45B3C, 13'h1BD0};
      ANSI_LONG_EXT_INV:  r = {2'h2, 21'h9C6BC, 13'h09C4};
      CURVE_OFF, CURVE_DEFINITE: r = 36'h0;
    endcase
    return r;
  endfunction

  state_t s;
  state_t next_s;

  logic signed [31:0] sx;
  logic signed [31:0] sy;
  logic signed [35:0] xsq;
  logic signed [35:0] ysq;
  logic [63:0]        mag_sc;
  logic [31:0]        gs6;
  logic [63:0]        gs6sq;
  logic               pick_over;
  logic               drop_under;
  logic [9:0]         ge;
  logic [35:0]        cp;
  logic [20:0]        dsel;
  logic [63:0]        base;
  logic [63:0]        op_full;
  logic [31:0]        op_ms;
  logic [31:0]        target;
  logic               is_inverse;
  logic               active;
  logic               tick;
  logic               wr;

  // 6*I2 = 2*(Ia + a^2 Ib + a Ic), sqrt3 in q10; drops the zero-sequence
  assign sx = (((32'(ia_re) <<< 1) - 32'(ib_re) - 32'(ic_re)) <<< 10)
            + `SQRT3_Q10 * (32'(ib_im) - 32'(ic_im));
  assign sy = (((32'(ia_im) <<< 1) - 32'(ib_im) - 32'(ic_im)) <<< 10)
            + `SQRT3_Q10 * (32'(ic_re) - 32'(ib_re));
  assign xsq = 36'(s.x) * 36'(s.x);
  assign ysq = 36'(s.y) * 36'(s.y);

  // squared compare avoids a square root; 1e4 cancels the percent scale
  assign mag_sc     = 64'(s.mag2) * 64'h2710;
  assign gs6        = NOM6 * 32'(s.pickup);
  assign gs6sq      = 64'(gs6) * 64'(gs6);
  assign pick_over  = mag_sc > gs6sq;
  assign drop_under = mag_sc * 64'(`DROP_DEN)
                    < gs6sq * 64'(`DROP_NUM);

  generate
    for (genvar i = 0; i < 10; i++) begin : g_bin
      assign ge[i] = (mag_sc << 4) >= gs6sq * 64'(BIN_SQ[i]);
    end
  endgenerate

  assign cp   = curve_par(s.curve);
  assign dsel = (cp[35:34] == 2'h0) ? D_A002[s.bin] :
                (cp[35:34] == 2'h1) ? D_A1[s.bin] : D_A2[s.bin];
  // top bin holds the twenty-times value for all larger currents
  assign base    = ((64'(cp[33:13]) * 64'(dsel))
                   >> ((cp[35:34] == 2'h2) ? 14 : 10))
                 + 64'(cp[12:0]);
  assign op_full = (base * 64'(s.mult)) / 64'h3E8;
  assign op_ms   = op_full[31:0];
  assign is_inverse = (s.curve != CURVE_OFF) && (s.curve != CURVE_DEFINITE);
  assign target = !is_inverse ? 32'(s.def_delay) :
                  (op_ms > 32'(s.min_delay)) ? op_ms : 32'(s.min_delay);
  assign active = (s.curve != CURVE_OFF) && !element_disable;
  assign tick   = s.tick_cnt == 32'(MS_CYCLES - 1);
  assign wr     = psel && penable && s.pready && pwrite;

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic [3:0]  b;
    logic [31:0] el;
    rd = 32'h0;
    hit = 1'b1;
    b = 4'h0;
    el = (s.elapsed == 32'hFFFFFFFF) ? s.elapsed : s.elapsed + 32'h1;
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.mag_valid = 1'b0;
    next_s.xy_valid = 1'b0;
    next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

    unique case (paddr)
      `REG_CURVE:      rd = 32'(s.curve);
      `REG_PICKUP:     rd = 32'(s.pickup);
      `REG_DEF_DELAY:  rd = 32'(s.def_delay);
      `REG_MIN_DELAY:  rd = 32'(s.min_delay);
      `REG_RST_DELAY:  rd = 32'(s.rst_delay);
      `REG_MULT:       rd = 32'(s.mult);
      `REG_STATUS:     rd = {24'h0, s.bin, 2'(s.phase), s.trip, s.started};
      `REG_IRQ_STATUS: rd = 32'(s.irq_status);
      `REG_IRQ_MASK:   rd = 32'(s.irq_mask);
      `REG_ELAPSED:    rd = s.elapsed;
      default:         hit = 1'b0;
    endcase
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = rd;
      next_s.pslverr = !hit;
    end

    // out-of-range pickup, delay and multiplier writes are clamped; curve writes above 0xC are refused
    if (wr) begin
      unique case (paddr)
        `REG_CURVE:
          if (pwdata[31:4] == 28'h0 && pwdata[3:0] <= 4'hC)
            next_s.curve = curve_t'(pwdata[3:0]);
        `REG_PICKUP:
          next_s.pickup = (pwdata < 32'(`PICKUP_MIN)) ? `PICKUP_MIN :
                          (pwdata > 32'(`PICKUP_MAX)) ? `PICKUP_MAX :
                          pwdata[7:0];
        `REG_DEF_DELAY:
          next_s.def_delay = (pwdata > 32'(`DELAY_MAX)) ? `DELAY_MAX :
                             pwdata[15:0];
        `REG_MIN_DELAY:
          next_s.min_delay = (pwdata > 32'(`DELAY_MAX)) ? `DELAY_MAX :
                             pwdata[15:0];
        `REG_RST_DELAY:
          next_s.rst_delay = (pwdata > 32'(`DELAY_MAX)) ? `DELAY_MAX :
                             pwdata[15:0];
        `REG_MULT:
          next_s.mult = (pwdata < 32'(`MULT_MIN)) ? `MULT_MIN :
                        (pwdata > 32'(`MULT_MAX)) ? `MULT_MAX :
                        pwdata[15:0];
        `REG_IRQ_STATUS: next_s.irq_status = s.irq_status & ~pwdata[1:0];
        `REG_IRQ_MASK:   next_s.irq_mask = pwdata[1:0];
        default: ;
      endcase
    end

    // three-stage measurement pipeline: phasors, then squared magnitude, then ratio bin
    if (phasor_valid) begin
      next_s.x = sx[27:10];
      next_s.y = sy[27:10];
      next_s.xy_valid = 1'b1;
    end
    if (s.xy_valid) begin
      next_s.mag2 = 36'(xsq + ysq);
      next_s.mag_valid = 1'b1;
    end
    if (s.mag_valid) begin
      for (int i = 0; i < 10; i++) begin
        b = b + 4'(ge[i]);
      end
      next_s.bin = b;
    end

    if (!active) begin
      next_s.started = 1'b0;
      next_s.trip = 1'b0;
      next_s.phase = PH_IDLE;
      next_s.elapsed = 32'h0;
      next_s.rst_cnt = 16'h0;
    end else begin
      if (s.mag_valid) begin
        if (pick_over)
          next_s.started = 1'b1;
        else if (drop_under)
          next_s.started = 1'b0;
      end
      if (tick) begin
        unique case (s.phase)
          PH_IDLE:
            if (s.started) next_s.phase = PH_TIMING;
          PH_TIMING:
            if (s.started) begin
              next_s.elapsed = el;
              if (el >= target) next_s.trip = 1'b1;
            end else if (is_inverse) begin
              next_s.phase = PH_RESETTING;
              next_s.rst_cnt = 16'h0;
            end else begin
              next_s.phase = PH_IDLE;
              next_s.elapsed = 32'h0;
            end
          PH_RESETTING:
            if (s.started && is_inverse) begin
              next_s.phase = PH_TIMING;
            end else if (!is_inverse || s.rst_cnt + 16'h1 >= s.rst_delay) begin
              next_s.phase = PH_IDLE;
              next_s.elapsed = 32'h0;
              next_s.rst_cnt = 16'h0;
            end else begin
              next_s.rst_cnt = s.rst_cnt + 16'h1;
            end
          default: next_s.phase = PH_IDLE;
        endcase
      end
      if (!next_s.started) next_s.trip = 1'b0;
    end

    // a rise in the same cycle as a clear keeps its bit set
    if (next_s.started && !s.started)
      next_s.irq_status[`IRQ_START_BIT] = 1'b1;
    if (next_s.trip && !s.trip)
      next_s.irq_status[`IRQ_TRIP_BIT] = 1'b1;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.curve <= CURVE_DEFINITE;
      s.pickup <= `PICKUP_RESET;
      s.def_delay <= `DELAY_RESET;
      s.min_delay <= `DELAY_RESET;
      s.rst_delay <= `DELAY_RESET;
      s.mult <= `MULT_RESET;
      s.phase <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign start   = s.started;
  assign trip    = s.trip;
  assign irq     = s.irq;

  property p_pick;
    @(posedge pclk) disable iff (!presetn)
    s.mag_valid && pick_over && active |=> start;
  endproperty
  a_pick: assert property (p_pick) else $error("start missed pickup");

  property p_hyst;
    @(posedge pclk) disable iff (!presetn)
    s.started && s.mag_valid && !drop_under && active |=> start;
  endproperty
  a_hyst: assert property (p_hyst) else $error("start dropped early");

  property p_off;
    @(posedge pclk) disable iff (!presetn)
    s.curve == CURVE_OFF |=> !start && !trip && s.elapsed == 32'h0;
  endproperty
  a_off: assert property (p_off) else $error("off not quiet");

  property p_disable;
    @(posedge pclk) disable iff (!presetn)
    element_disable |=> !start && !trip;
  endproperty
  a_disable: assert property (p_disable) else $error("disable ignored");

  property p_def;
    @(posedge pclk) disable iff (!presetn)
    $rose(trip) && $past(s.curve) == CURVE_DEFINITE
      |-> s.elapsed >= 32'($past(s.def_delay));
  endproperty
  a_def: assert property (p_def) else $error("definite trip early");

  property p_min;
    @(posedge pclk) disable iff (!presetn)
    $rose(trip) && $past(is_inverse) |-> s.elapsed >= 32'($past(s.min_delay));
  endproperty
  a_min: assert property (p_min) else $error("trip before min delay");

  property p_curve;
    @(posedge pclk) disable iff (!presetn)
    $rose(trip) && $past(is_inverse) |-> s.elapsed >= $past(op_ms);
  endproperty
  a_curve: assert property (p_curve) else $error("trip before curve");

  property p_trip_start;
    @(posedge pclk) disable iff (!presetn)
    trip |-> start && s.phase == PH_TIMING;
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip alone");

  property p_reset_hold;
    @(posedge pclk) disable iff (!presetn)
    s.phase == PH_RESETTING && !tick && active |=> $stable(s.elapsed);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("time lost");

  property p_ranges;
    @(posedge pclk) disable iff (!presetn)
    s.pickup >= `PICKUP_MIN && s.pickup <= `PICKUP_MAX
      && s.mult >= `MULT_MIN && s.mult <= `MULT_MAX;
  endproperty
  a_ranges: assert property (p_ranges) else $error("setting out of range");

  c_def_trip: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(trip) && s.curve == CURVE_DEFINITE);
  c_inv_trip: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(trip) && is_inverse);
  c_resume: cover property (@(posedge pclk) disable iff (!presetn)
    s.phase == PH_RESETTING ##1 s.phase == PH_TIMING);
  c_flatten: cover property (@(posedge pclk) disable iff (!presetn)
    s.bin == `FLATTEN_BIN && start);

endmodule

//--- neg_seq_overcurrent_element_tb.sv
`timescale 1ns/1ps
`include "neg_seq_overcurrent_defs.svh"

module neg_seq_overcurrent_element_tb;
  import neg_seq_overcurrent_pkg::*;
  localparam int MSC = 10;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic signed [15:0] ia_re;
  logic signed [15:0] ia_im;
  logic signed [15:0] ib_re;
  logic signed [15:0] ib_im;
  logic signed [15:0] ic_re;
  logic signed [15:0] ic_im;
  logic               phasor_valid;
  logic               element_disable;
  logic               start;
  logic               trip;
  logic               irq;
  logic [15:0]        level_pct;
  logic               neg_order;
  int                 n_fail;
  int                 checks;
  int                 n;
  real                t_ax;
  logic [31:0]        rd;
  logic               er;
  logic [7:0]         ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C,
                                 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0]        rv [8] = '{32'h1, 32'h32, 32'h64, 32'h64,
                                 32'h64, 32'h64, 32'h0, 32'h0};

  neg_seq_overcurrent_element #(.MS_CYCLES(MSC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ia_re(ia_re), .ia_im(ia_im),
    .ib_re(ib_re), .ib_im(ib_im), .ic_re(ic_re), .ic_im(ic_im),
    .phasor_valid(phasor_valid), .element_disable(element_disable),
    .start(start), .trip(trip), .irq(irq));

  phasor_source src (
    .pclk(pclk), .presetn(presetn), .level_pct(level_pct),
    .neg_order(neg_order), .ia_re(ia_re), .ia_im(ia_im), .ib_re(ib_re),
    .ib_im(ib_im), .ic_re(ic_re), .ic_im(ic_im),
    .phasor_valid(phasor_valid));

  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_word(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic check_flag(string nm, logic e, logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_range(string nm, int lo, int hi, int g);
    checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // pready is read at the edge itself, before that edge's updates land
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check_word("register", e, rd);
  endtask

  task automatic wait_for(input int which, input logic v, input int lim,
                          output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge pclk);
      if ((which == 0 ? start : trip) === v) return;
    end
    n_fail++;
    $display("MISMATCH output wait expected %b seen timeout", v);
    report_and_stop();
  endtask

  function automatic real curve_ms(real k, real c, real a, real m);
    return m / 100.0 * (k / (20.0 ** a - 1.0) + c) * 1000.0;
  endfunction

  task automatic inv_run(input curve_t crv, input logic [31:0] mul,
                         input logic [31:0] mind, input real t);
    int cnt;
    wr(`REG_CURVE, 32'(crv));
    wr(`REG_MULT, mul);
    wr(`REG_MIN_DELAY, mind);
    level_pct <= 16'h00C8;
    wait_for(0, 1'b1, 50, cnt);
    wait_for(1, 1'b1, int'(t + 10.0) * MSC, cnt);
    check_range("inverse trip", int'(t - 1.0) * MSC, int'(t + 3.0) * MSC, cnt);
    level_pct <= 16'h0000;
    wait_for(0, 1'b0, 50, cnt);
    repeat (30 * MSC) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    element_disable = 1'b0;
    level_pct = 16'h0000;
    neg_order = 1'b1;
    n_fail = 0;
    checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    apb(8'h28, 1'b0, 32'h0);
    check_flag("unmapped error", 1'b1, er);
    check_word("unmapped data", 32'h0, rd);
    wr(`REG_PICKUP, 32'h2);
    rd_chk(`REG_PICKUP, 32'h5);
    wr(`REG_PICKUP, 32'hFA);
    rd_chk(`REG_PICKUP, 32'hC8);
    wr(`REG_PICKUP, 32'h32);
    wr(`REG_CURVE, 32'hD);
    rd_chk(`REG_CURVE, 32'h1);
    level_pct <= 16'h003C;
    wait_for(0, 1'b1, 20, n);
    repeat (2) @(posedge pclk);
    check_flag("irq masked", 1'b0, irq);
    rd_chk(`REG_IRQ_STATUS, 32'h1);
    wr(`REG_IRQ_MASK, 32'h3);
    repeat (2) @(posedge pclk);
    check_flag("irq raised", 1'b1, irq);
    wr(`REG_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    check_flag("irq cleared", 1'b0, irq);
    level_pct <= 16'h0031;
    repeat (20) @(posedge pclk);
    check_flag("start hold", 1'b1, start);
    level_pct <= 16'h002D;
    wait_for(0, 1'b0, 20, n);
    neg_order <= 1'b0;
    level_pct <= 16'h0096;
    repeat (20) @(posedge pclk);
    check_flag("positive set", 1'b0, start);
    neg_order <= 1'b1;
    wr(`REG_DEF_DELAY, 32'h5);
    level_pct <= 16'h0050;
    wait_for(0, 1'b1, 20, n);
    wait_for(1, 1'b1, 200, n);
    check_range("definite trip", 5 * MSC, 8 * MSC, n);
    rd_chk(`REG_IRQ_STATUS, 32'h3);
    element_disable <= 1'b1;
    wait_for(1, 1'b0, 5, n);
    check_flag("start disabled", 1'b0, start);
    level_pct <= 16'h0000;
    repeat (12) @(posedge pclk);
    element_disable <= 1'b0;
    wr(`REG_IRQ_STATUS, 32'h3);
    rd_chk(`REG_IRQ_STATUS, 32'h0);
    wr(`REG_CURVE, 32'h0);
    level_pct <= 16'h0050;
    repeat (30) @(posedge pclk);
    check_flag("off start", 1'b0, start);
    check_flag("off trip", 1'b0, trip);
    level_pct <= 16'h0000;
    wr(`REG_PICKUP, 32'h5);
    wr(`REG_RST_DELAY, 32'h14);
    t_ax = curve_ms(28.2, 0.1217, 2.0, 100.0);
    inv_run(ANSI_EXT_INV, 32'h64, 32'h0, t_ax);
    inv_run(ANSI_EXT_INV, 32'hC8, 32'h0, 2.0 * t_ax);
    inv_run(IEC_EXT_INV, 32'h64, 32'h0, curve_ms(80.0, 0.0, 2.0, 100.0));
    wr(`REG_CURVE, 32'(ANSI_EXT_INV));
    level_pct <= 16'h00C8;
    wait_for(0, 1'b1, 50, n);
    repeat (100 * MSC) @(posedge pclk);
    level_pct <= 16'h0000;
    wait_for(0, 1'b0, 50, n);
    repeat (5 * MSC) @(posedge pclk);
    level_pct <= 16'h00C8;
    wait_for(0, 1'b1, 50, n);
    wait_for(1, 1'b1, 300 * MSC, n);
    check_range("resumed trip", int'(t_ax - 104.0) * MSC,
                int'(t_ax - 95.0) * MSC, n);
    level_pct <= 16'h0000;
    wait_for(0, 1'b0, 50, n);
    repeat (30 * MSC) @(posedge pclk);
    inv_run(ANSI_EXT_INV, 32'h64, 32'h12C, 300.0);
    report_and_stop();
  end
endmodule

//--- neg_seq_overcurrent_pkg.sv
package neg_seq_overcurrent_pkg;

  typedef enum logic [3:0] {
    CURVE_OFF,
    CURVE_DEFINITE,
    IEC_INV,
    IEC_VERY_INV,
    IEC_EXT_INV,
    IEC_LONG_INV,
    ANSI_INV,
    ANSI_MOD_INV,
    ANSI_VERY_INV,
    ANSI_EXT_INV,
    ANSI_LONG_INV,
    ANSI_LONG_VERY_INV,
    ANSI_LONG_EXT_INV
  } curve_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_TIMING,
    PH_RESETTING
  } phase_t;

endpackage

//--- phasor_source.sv
`timescale 1ns/1ps

module phasor_source #(
  parameter int NOM_UNITS = 1000
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [15:0]   level_pct,
  input  wire logic          neg_order,
  output logic signed [15:0] ia_re,
  output logic signed [15:0] ia_im,
  output logic signed [15:0] ib_re,
  output logic signed [15:0] ib_im,
  output logic signed [15:0] ic_re,
  output logic signed [15:0] ic_im,
  output logic               phasor_valid
);
  typedef struct packed {
    logic [1:0]         cnt;
    logic               valid;
    logic signed [15:0] ar;
    logic signed [15:0] ai;
    logic signed [15:0] br;
    logic signed [15:0] bi;
    logic signed [15:0] cr;
    logic signed [15:0] ci;
  } src_state_t;

  src_state_t state;
  src_state_t next_state;
  int         mag;
  int         half;
  int         quad;

  // acb rotation is pure negative sequence, abc pure positive sequence
  always_comb begin
    mag = int'(level_pct) * NOM_UNITS / 100;
    half = mag / 2;
    quad = mag * 866 / 1000;
    next_state = state;
    next_state.cnt = state.cnt + 2'h1;
    next_state.valid = (state.cnt == 2'h3);
    if (state.cnt == 2'h3) begin
      next_state.ar = 16'(mag);
      next_state.ai = 16'sh0000;
      next_state.br = 16'(-half);
      next_state.bi = neg_order ? 16'(quad) : 16'(-quad);
      next_state.cr = 16'(-half);
      next_state.ci = neg_order ? 16'(-quad) : 16'(quad);
    end
  end

  // words change only together with the pulse, so a sample is never torn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ia_re = state.ar;
  assign ia_im = state.ai;
  assign ib_re = state.br;
  assign ib_im = state.bi;
  assign ic_re = state.cr;
  assign ic_im = state.ci;
  assign phasor_valid = state.valid;
endmodule
